// ===== rbatd_backoff.sv
// truncated binary exponential backoff timer
`timescale 1ns/100ps
module rbatd_backoff #(
  parameter int SLOT_CYC = rbatd_pkg::SLOT_CYC_DEF
) (
  input  wire logic  i_clk,
  input  wire logic  i_resetn,
  rbatd_bo_if.timer  bo
);
  import rbatd_pkg::*;

  logic [15:0] lfsr_r, lfsr_nxt;
  logic [9:0]  slots_r, slots_nxt;
  logic [23:0] cnt_r, cnt_nxt;
  logic        run_r, run_nxt;
  logic [9:0]  mask;

  always_comb begin
    lfsr_nxt  = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
    slots_nxt = slots_r;
    cnt_nxt   = cnt_r;
    run_nxt   = run_r;
    // k is capped at ten, so at most 1023 slot times
    mask = (bo.attempt >= 4'(BACKOFF_MAXK)) ? 10'h3ff : 10'((11'h001 << bo.attempt) - 11'h001);
    if (bo.start) begin
      slots_nxt = lfsr_r[9:0] & mask;
      cnt_nxt   = 24'h00_0000;
      run_nxt   = 1'b1;
    end else if (run_r) begin
      if (slots_r == 10'h000) begin
        run_nxt = 1'b0;
      end else if (cnt_r == 24'(SLOT_CYC - 1)) begin
        cnt_nxt   = 24'h00_0000;
        slots_nxt = slots_r - 10'h001;
      end else begin
        cnt_nxt = cnt_r + 24'h00_0001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      lfsr_r  <= 16'hace1;
      slots_r <= 10'h000;
      cnt_r   <= 24'h00_0000;
      run_r   <= 1'b0;
    end else begin
      lfsr_r  <= lfsr_nxt;
      slots_r <= slots_nxt;
      cnt_r   <= cnt_nxt;
      run_r   <= run_nxt;
    end
  end

  assign bo.done = !run_r;
endmodule : rbatd_backoff

// ===== rbatd_bo_if.sv
// backoff request and status between the dma core and its backoff timer
`timescale 1ns/100ps
interface rbatd_bo_if;
  logic       start;
  logic [3:0] attempt;
  logic       done;
  modport core  (output start, output attempt, input done);
  modport timer (input start, input attempt, output done);
endinterface : rbatd_bo_if

// ===== rbatd_checker.sv
// port assertions for the ring buffer and transmit dma
`timescale 1ns/100ps
module rbatd_checker
  import rbatd_pkg::*;
(
  input wire logic        I_MCLK,
  input wire logic        I_RESETN,
  input wire logic        I_RX_PAGE_REQ,
  input wire logic [7:0]  I_RX_PAGE,
  input wire logic [7:0]  O_RING_READ_LIMIT_PAGE,
  input wire logic        O_RX_PAGE_DENY,
  input wire logic        O_REMOTE_GO,
  input wire logic [7:0]  O_REMOTE_START_ADDR_LOW,
  input wire logic [7:0]  O_REMOTE_START_ADDR_HIGH,
  input wire logic        O_MEM_REQ,
  input wire logic        I_MEM_ACK,
  input wire logic [15:0] O_MEM_ADDR,
  input wire logic        I_TX_REQUEST,
  input wire logic        O_BUSY,
  input wire logic        I_CRS,
  input wire logic        I_COL,
  input wire logic        O_TX_EN,
  input wire logic        O_TXD,
  input wire logic [7:0]  O_TX_STATUS_REG,
  input wire logic [3:0]  O_COLLISION_COUNT_REG
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESETN);
  logic [10:0] gap_r;
  logic [10:0] gap_nxt;
  always_comb begin
    gap_nxt = gap_r;
    if (I_CRS || O_TX_EN) gap_nxt = 11'h000;
    else if (gap_r < IFG_CYC) gap_nxt = gap_r + 11'h001;
  end
  always_ff @(posedge I_MCLK) gap_r <= I_RESETN ? gap_nxt : 11'h000;
  sequence tx_launch;
    $rose(O_TX_EN);
  endsequence
  sequence mem_wait;
    O_MEM_REQ && !I_MEM_ACK;
  endsequence
  deny_match_a: assert property (O_RX_PAGE_DENY == (I_RX_PAGE_REQ && I_RX_PAGE == O_RING_READ_LIMIT_PAGE))
    else $error("page deny wrong");
  remote_src_a: assert property (O_REMOTE_GO |-> {O_REMOTE_START_ADDR_HIGH, O_REMOTE_START_ADDR_LOW} ==
    {O_RING_READ_LIMIT_PAGE, 8'h00} ##1 !O_REMOTE_GO) else $error("remote start wrong");
  mem_hold_a: assert property (mem_wait |=> O_MEM_REQ && $stable(O_MEM_ADDR))
    else $error("memory request dropped");
  col_stop_a: assert property (O_TX_EN && I_COL |=> !O_TX_EN)
    else $error("collision not stopped");
  abort_zero_a: assert property ($rose(O_TX_STATUS_REG[TSR_ABT_BIT]) |-> O_COLLISION_COUNT_REG == 4'h0)
    else $error("abort count not zero");
  gap_start_a: assert property (tx_launch |-> gap_r >= 11'(IFG_CYC - 4))
    else $error("gap too short");
  pre_first_a: assert property (tx_launch |-> O_TXD ##25 !O_TXD)
    else $error("preamble wrong");
  req_clear_a: assert property (I_TX_REQUEST && !O_BUSY |=> O_TX_STATUS_REG == TSR_RESET)
    else $error("status not cleared");
endmodule : rbatd_checker
bind rbatd_top rbatd_checker u_chk (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN), .I_RX_PAGE_REQ(I_RX_PAGE_REQ),
  .I_RX_PAGE(I_RX_PAGE), .O_RING_READ_LIMIT_PAGE(O_RING_READ_LIMIT_PAGE), .O_RX_PAGE_DENY(O_RX_PAGE_DENY),
  .O_REMOTE_GO(O_REMOTE_GO), .O_REMOTE_START_ADDR_LOW(O_REMOTE_START_ADDR_LOW), .O_MEM_REQ(O_MEM_REQ),
  .O_REMOTE_START_ADDR_HIGH(O_REMOTE_START_ADDR_HIGH), .I_MEM_ACK(I_MEM_ACK), .O_MEM_ADDR(O_MEM_ADDR),
  .I_TX_REQUEST(I_TX_REQUEST), .O_BUSY(O_BUSY), .I_CRS(I_CRS), .I_COL(I_COL), .O_TX_EN(O_TX_EN), .O_TXD(O_TXD),
  .O_TX_STATUS_REG(O_TX_STATUS_REG), .O_COLLISION_COUNT_REG(O_COLLISION_COUNT_REG));

// ===== rbatd_mem_model.sv
// local buffer memory model answering the dma memory requests
`timescale 1ns/100ps
module rbatd_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_req,
  input  wire logic        i_we,
  input  wire logic        i_wide,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_slow,
  output logic             o_ack,
  output logic      [15:0] o_rdata
);
  logic [7:0]  mem [0:65535];
  logic [15:0] ev;
  int          wait_cnt;
  assign ev = {i_addr[15:1], 1'b0};
  initial begin
    o_ack = 1'b0;
    o_rdata = 16'h0000;
    wait_cnt = 0;
  end
  always @(posedge i_clk) begin
    o_ack <= 1'b0;
    // read lanes flip to their inverse on every cycle without an acknowledge
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack) begin
      if (wait_cnt < (i_slow ? 4 : 0)) begin
        wait_cnt <= wait_cnt + 1;
      end else begin
        wait_cnt <= 0;
        o_ack <= 1'b1;
        o_rdata <= i_wide ? {mem[ev + 1], mem[ev]} : {~mem[i_addr], mem[i_addr]};
        if (i_we && i_wide) begin
          mem[ev] <= i_wdata[7:0];
          mem[ev + 1] <= i_wdata[15:8];
        end else if (i_we) begin
          mem[i_addr] <= i_wdata[7:0];
        end
      end
    end
  end
endmodule : rbatd_mem_model

// ===== rbatd_pkg.sv
// shared constants and types for the ring buffer and transmit dma block
package rbatd_pkg;
  localparam int          CLK_MHZ      = 250;
  localparam int          BIT_NS       = 100;
  localparam int          BIT_CYC      = (BIT_NS * CLK_MHZ) / 1000;
  localparam int          IFG_NS       = 6400;
  localparam int          IFG_CYC      = (IFG_NS * CLK_MHZ + 999) / 1000;
  localparam int          SLOT_BITS    = 512;
  localparam int          SLOT_CYC_DEF = SLOT_BITS * BIT_CYC;
  localparam int          BACKOFF_MAXK = 10;
  localparam logic [3:0]  NCR_LAST     = 4'hf;
  localparam logic [2:0]  PRE_SFD_IDX  = 3'h6;
  localparam logic [2:0]  PRE_LAST_IDX = 3'h7;
  localparam logic [7:0]  PRE_BYTE     = 8'h55;
  localparam logic [7:0]  SFD_BYTE     = 8'hd5;
  localparam logic [31:0] CRC_POLY     = 32'hedb8_8320;
  localparam logic [31:0] CRC_INIT     = 32'hffff_ffff;
  localparam logic [5:0]  CRC_BITS     = 6'h20;
  localparam logic [7:0]  TSR_RESET    = 8'h00;
  localparam int          TSR_PTX_BIT  = 0;
  localparam int          TSR_COL_BIT  = 2;
  localparam int          TSR_ABT_BIT  = 3;
  localparam logic [15:0] HDR_NEXT_OFS = 16'h0001;
  localparam logic [1:0]  HDR_LAST_RD  = 2'h3;

  typedef enum logic [3:0] {
    RBATD_IDLE    = 4'h0,
    RBATD_HDR     = 4'h1,
    RBATD_SP_RD   = 4'h3,
    RBATD_SP_WAIT = 4'h2,
    RBATD_TX_WAIT = 4'h6,
    RBATD_TX_PRE  = 4'h7,
    RBATD_TX_DATA = 4'h5,
    RBATD_TX_CRC  = 4'h4
  } rbatd_state_e;
endpackage : rbatd_pkg

// ===== rbatd_top.sv
// receive ring pointer upkeep, header store, send packet and transmit dma
//
// What this block does
// - send packet reads header at read limit, starts remote channel, then frees pages
// - next page pointer is stored as second byte of every receive header
// - 16-bit little-endian header: status low, next page high, then count bytes
// - byte-swapped 16-bit mode swaps data bytes and count bytes alike
// - 8-bit mode stores status, next page, count low, count high, then data
// - transmit request clears transmit status and prefetches unless receiving
// - device makes preamble, sync and crc; byte count excludes them
// - transmit starts after 6.4 us gap, one byte buffered, backoff expired
// - carrier sense before first buffered byte abandons the transmit start
// - collision flushes buffer, rewinds pointers, sets collision flag, counts collisions
// - sixteenth collision aborts, sets abort flag, collision count reads zero
// - frame bytes go out in order, each least significant bit first
// - entering the read limit page denies the page so stored packets survive
// - on accept, header is written at the first page used by the packet
`timescale 1ns/100ps
module rbatd_top #(
  parameter int SLOT_CYC = rbatd_pkg::SLOT_CYC_DEF
) (
  input  wire logic        I_MCLK,
  input  wire logic        I_RESETN,
  input  wire logic        I_BYTE_SWAP_SELECT,
  input  wire logic        I_WORD_WIDTH_SELECT,
  input  wire logic [7:0]  I_RING_FIRST_PAGE,
  input  wire logic [7:0]  I_RING_END_PAGE,
  input  wire logic        I_RING_READ_LIMIT_WR,
  input  wire logic [7:0]  I_RING_READ_LIMIT_DATA,
  output logic      [7:0]  O_RING_READ_LIMIT_PAGE,
  input  wire logic        I_SEND_PKT,
  input  wire logic        I_REMOTE_DONE,
  output logic             O_REMOTE_GO,
  output logic      [7:0]  O_REMOTE_START_ADDR_LOW,
  output logic      [7:0]  O_REMOTE_START_ADDR_HIGH,
  output logic      [15:0] O_REMOTE_COUNT,
  input  wire logic        I_RX_PAGE_REQ,
  input  wire logic [7:0]  I_RX_PAGE,
  output logic             O_RX_PAGE_DENY,
  input  wire logic        I_RX_ACCEPT,
  input  wire logic [7:0]  I_RING_WRITE_PAGE,
  input  wire logic [7:0]  I_RX_NEXT_PAGE,
  input  wire logic [7:0]  I_RX_STATUS,
  input  wire logic [15:0] I_RX_COUNT,
  input  wire logic        I_RX_WR,
  input  wire logic [15:0] I_RX_ADDR,
  input  wire logic [15:0] I_RX_WORD,
  output logic             O_RX_WR_READY,
  input  wire logic [7:0]  I_TX_PAGE_START,
  input  wire logic [7:0]  I_TX_COUNT_LOW,
  input  wire logic [7:0]  I_TX_COUNT_HIGH,
  input  wire logic        I_TX_REQUEST,
  input  wire logic        I_RECEIVING,
  input  wire logic        I_CRS,
  input  wire logic        I_COL,
  output logic             O_TXD,
  output logic             O_TX_EN,
  output logic      [7:0]  O_TX_STATUS_REG,
  output logic      [3:0]  O_COLLISION_COUNT_REG,
  output logic             O_TX_DONE,
  output logic             O_BUSY,
  output logic             O_MEM_REQ,
  output logic             O_MEM_WE,
  output logic             O_MEM_WIDE,
  output logic      [15:0] O_MEM_ADDR,
  output logic      [15:0] O_MEM_WDATA,
  input  wire logic        I_MEM_ACK,
  input  wire logic [15:0] I_MEM_RDATA
);
  import rbatd_pkg::*;

  // byte at a byte address out of a fetched word, honouring width and swap
  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic a0, input logic wide,
                                           input logic swap);
    pick_byte = (wide && (a0 ^ swap)) ? w[15:8] : w[7:0];
  endfunction : pick_byte

  rbatd_bo_if bo ();
  rbatd_backoff #(.SLOT_CYC(SLOT_CYC)) u_backoff (.i_clk(I_MCLK), .i_resetn(I_RESETN), .bo(bo));

  rbatd_state_e st_r, st_nxt;
  logic [7:0]  bnd_r, bnd_nxt, hnext_r, hnext_nxt, hstat_r, hstat_nxt, hpage_r, hpage_nxt;
  logic [15:0] hcnt_r, hcnt_nxt, rcnt_r, rcnt_nxt;
  logic [7:0]  rnext_r, rnext_nxt, tsr_r, tsr_nxt, nb_r, nb_nxt, sh_r, sh_nxt;
  logic        hpend_r, hpend_nxt, go_r, go_nxt, done_r, done_nxt, nbv_r, nbv_nxt;
  logic [1:0]  step_r, step_nxt;
  logic        req_r, req_nxt, we_r, we_nxt, wide_r, wide_nxt, txd_r, txd_nxt, txen_r, txen_nxt;
  logic [15:0] addr_r, addr_nxt, wdata_r, wdata_nxt, fidx_r, fidx_nxt, left_r, left_nxt;
  logic [3:0]  ncr_r, ncr_nxt;
  logic [4:0]  bdiv_r, bdiv_nxt;
  logic [10:0] ifg_r, ifg_nxt;
  logic [5:0]  bitc_r, bitc_nxt;
  logic [2:0]  prec_r, prec_nxt;
  logic [31:0] crc_r, crc_nxt;
  logic        bit_en, ifg_done, in_tx, on_line, ack;
  logic [15:0] tcount;

  assign tcount   = {I_TX_COUNT_HIGH, I_TX_COUNT_LOW};
  assign bit_en   = (bdiv_r == 5'(BIT_CYC - 1));
  assign ifg_done = (ifg_r == 11'(IFG_CYC));
  assign in_tx    = (st_r == RBATD_TX_WAIT) || on_line;
  assign on_line  = (st_r == RBATD_TX_PRE) || (st_r == RBATD_TX_DATA) || (st_r == RBATD_TX_CRC);
  assign ack      = req_r && I_MEM_ACK;

  always_comb begin
    st_nxt = st_r;  bnd_nxt = bnd_r;  hnext_nxt = hnext_r;  hstat_nxt = hstat_r;
    hpage_nxt = hpage_r;  hcnt_nxt = hcnt_r;  hpend_nxt = hpend_r;  rcnt_nxt = rcnt_r;
    rnext_nxt = rnext_r;  tsr_nxt = tsr_r;  nb_nxt = nb_r;  nbv_nxt = nbv_r;  sh_nxt = sh_r;
    step_nxt = step_r;  req_nxt = req_r;  we_nxt = we_r;  wide_nxt = wide_r;  addr_nxt = addr_r;
    wdata_nxt = wdata_r;  fidx_nxt = fidx_r;  left_nxt = left_r;  ncr_nxt = ncr_r;
    txd_nxt = txd_r;  txen_nxt = txen_r;  bitc_nxt = bitc_r;  prec_nxt = prec_r;  crc_nxt = crc_r;
    go_nxt = 1'b0;  done_nxt = 1'b0;  bo.start = 1'b0;  bo.attempt = ncr_r;
    bdiv_nxt = bit_en ? 5'h00 : bdiv_r + 5'h01;
    // gap timer restarts whenever the medium or our own transmitter is busy
    if (I_CRS || txen_r) ifg_nxt = 11'h000;
    else if (!ifg_done) ifg_nxt = ifg_r + 11'h001;
    else ifg_nxt = ifg_r;
    if (ack) req_nxt = 1'b0;

    case (st_r)
      RBATD_IDLE: begin
        if (hpend_r) begin
          st_nxt   = RBATD_HDR;
          step_nxt = 2'h0;
        end else if (I_TX_REQUEST) begin
          tsr_nxt  = TSR_RESET;
          ncr_nxt  = 4'h0;
          fidx_nxt = 16'h0000;
          nbv_nxt  = 1'b0;
          st_nxt   = RBATD_TX_WAIT;
        end else if (I_SEND_PKT) begin
          st_nxt   = RBATD_SP_RD;
          step_nxt = 2'h1;
        end else if (I_RX_WR && !req_r) begin
          req_nxt   = 1'b1;
          we_nxt    = 1'b1;
          wide_nxt  = I_WORD_WIDTH_SELECT;
          addr_nxt  = I_RX_ADDR;
          wdata_nxt = (I_WORD_WIDTH_SELECT && I_BYTE_SWAP_SELECT) ?
                      {I_RX_WORD[7:0], I_RX_WORD[15:8]} : I_RX_WORD;
        end
      end
      RBATD_HDR: if (!req_r) begin
        if ((step_r == 2'h2 && I_WORD_WIDTH_SELECT) || (step_r == 2'h0 && hpend_r == 1'b0)) begin
          st_nxt = RBATD_IDLE;
        end else begin
          req_nxt  = 1'b1;
          we_nxt   = 1'b1;
          wide_nxt = I_WORD_WIDTH_SELECT;
          step_nxt = step_r + 2'h1;
          if (step_r == HDR_LAST_RD && !I_WORD_WIDTH_SELECT) hpend_nxt = 1'b0;
          if (I_WORD_WIDTH_SELECT) begin
            addr_nxt  = {hpage_r, 6'h00, step_r[0], 1'b0};
            // count bytes are swapped like data when the swap setting is on
            wdata_nxt = (step_r == 2'h0) ? {hnext_r, hstat_r} :
                        (I_BYTE_SWAP_SELECT ? {hcnt_r[7:0], hcnt_r[15:8]} : hcnt_r);
            if (step_r == 2'h1) hpend_nxt = 1'b0;
          end else begin
            addr_nxt = {hpage_r, 6'h00, step_r};
            case (step_r)
              2'h0:    wdata_nxt = {8'h00, hstat_r};
              2'h1:    wdata_nxt = {8'h00, hnext_r};
              2'h2:    wdata_nxt = {8'h00, hcnt_r[7:0]};
              default: wdata_nxt = {8'h00, hcnt_r[15:8]};
            endcase
          end
        end
      end
      RBATD_SP_RD: begin
        if (ack) begin
          case (step_r)
            2'h1:    rnext_nxt = pick_byte(I_MEM_RDATA, addr_r[0], wide_r, I_BYTE_SWAP_SELECT);
            2'h2:    rcnt_nxt[7:0] = pick_byte(I_MEM_RDATA, addr_r[0], wide_r, I_BYTE_SWAP_SELECT);
            default: rcnt_nxt[15:8] = pick_byte(I_MEM_RDATA, addr_r[0], wide_r, I_BYTE_SWAP_SELECT);
          endcase
          step_nxt = step_r + 2'h1;
          if (step_r == HDR_LAST_RD) begin
            go_nxt = 1'b1;
            st_nxt = RBATD_SP_WAIT;
          end
        end else if (!req_r) begin
          req_nxt  = 1'b1;
          we_nxt   = 1'b0;
          wide_nxt = I_WORD_WIDTH_SELECT;
          addr_nxt = {bnd_r, 8'h00} + {14'h0000, step_r};
        end
      end
      RBATD_SP_WAIT: if (I_REMOTE_DONE) begin
        // free pages up to the one before the next packet, wrapping the ring
        bnd_nxt = (rnext_r - 8'h01 < I_RING_FIRST_PAGE) ? I_RING_END_PAGE - 8'h01 :
                  rnext_r - 8'h01;
        st_nxt  = RBATD_IDLE;
      end
      RBATD_TX_WAIT: begin
        if (I_CRS && !nbv_r) begin
          st_nxt = RBATD_IDLE;
        end else if (ifg_done && nbv_r && bo.done && bit_en) begin
          st_nxt   = RBATD_TX_PRE;
          txen_nxt = 1'b1;
          // first bit leaves with the enable, so no stray partial bit leads the frame
          txd_nxt  = PRE_BYTE[0];
          sh_nxt   = PRE_BYTE;
          bitc_nxt = 6'h01;
          prec_nxt = 3'h0;
          crc_nxt  = CRC_INIT;
          left_nxt = tcount;
        end
      end
      RBATD_TX_PRE, RBATD_TX_DATA: if (bit_en) begin
        txd_nxt  = sh_r[bitc_r[2:0]];
        bitc_nxt = bitc_r + 6'h01;
        if (st_r == RBATD_TX_DATA)
          crc_nxt = {1'b0, crc_r[31:1]} ^ ((crc_r[0] ^ sh_r[bitc_r[2:0]]) ? CRC_POLY : 32'h0000_0000);
        if (bitc_r[2:0] == 3'h7) begin
          bitc_nxt = 6'h00;
          prec_nxt = prec_r + 3'h1;
          if (st_r == RBATD_TX_PRE && prec_r == PRE_SFD_IDX) begin
            sh_nxt = SFD_BYTE;
          end else if (st_r == RBATD_TX_PRE && prec_r != PRE_LAST_IDX) begin
            sh_nxt = PRE_BYTE;
          end else if (left_r == 16'h0000) begin
            st_nxt = RBATD_TX_CRC;
          end else begin
            st_nxt   = RBATD_TX_DATA;
            sh_nxt   = nb_r;
            nbv_nxt  = 1'b0;
            left_nxt = left_r - 16'h0001;
          end
        end
      end
      RBATD_TX_CRC: if (bit_en) begin
        if (bitc_r == CRC_BITS) begin
          txen_nxt = 1'b0;
          txd_nxt  = 1'b0;
          tsr_nxt[TSR_PTX_BIT] = 1'b1;
          done_nxt = 1'b1;
          st_nxt   = RBATD_IDLE;
        end else begin
          txd_nxt  = ~crc_r[bitc_r[4:0]];
          bitc_nxt = bitc_r + 6'h01;
        end
      end
      default: st_nxt = RBATD_IDLE;
    endcase

    // prefetch holds one byte ahead; the line stalls nothing if memory is slow
    if (in_tx && ack) begin
      nb_nxt   = pick_byte(I_MEM_RDATA, addr_r[0], wide_r, I_BYTE_SWAP_SELECT);
      nbv_nxt  = 1'b1;
      fidx_nxt = fidx_r + 16'h0001;
    end else if (in_tx && !req_r && !nbv_r && fidx_r < tcount && !I_RECEIVING) begin
      req_nxt  = 1'b1;
      we_nxt   = 1'b0;
      wide_nxt = I_WORD_WIDTH_SELECT;
      addr_nxt = {I_TX_PAGE_START, 8'h00} + fidx_r;
    end

    if (on_line && I_COL) begin
      txen_nxt = 1'b0;
      txd_nxt  = 1'b0;
      nbv_nxt  = 1'b0;
      fidx_nxt = 16'h0000;
      req_nxt  = 1'b0;
      tsr_nxt[TSR_COL_BIT] = 1'b1;
      if (ncr_r == NCR_LAST) begin
        tsr_nxt[TSR_ABT_BIT] = 1'b1;
        ncr_nxt  = 4'h0;
        done_nxt = 1'b1;
        st_nxt   = RBATD_IDLE;
      end else begin
        ncr_nxt    = ncr_r + 4'h1;
        bo.start   = 1'b1;
        bo.attempt = ncr_r + 4'h1;
        st_nxt     = RBATD_TX_WAIT;
      end
    end

    if (I_RING_READ_LIMIT_WR) bnd_nxt = I_RING_READ_LIMIT_DATA;
    // a header arriving while the last one is still queued wins
    if (I_RX_ACCEPT) begin
      hpend_nxt = 1'b1;
      hpage_nxt = I_RING_WRITE_PAGE;
      hnext_nxt = I_RX_NEXT_PAGE;
      hstat_nxt = I_RX_STATUS;
      hcnt_nxt  = I_RX_COUNT;
    end
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      st_r <= RBATD_IDLE;  bnd_r <= 8'h00;  hnext_r <= 8'h00;  hstat_r <= 8'h00;  hpage_r <= 8'h00;
      hcnt_r <= 16'h0000;  hpend_r <= 1'b0;  rcnt_r <= 16'h0000;  rnext_r <= 8'h00;
      tsr_r <= TSR_RESET;  nb_r <= 8'h00;  nbv_r <= 1'b0;  sh_r <= 8'h00;  step_r <= 2'h0;
      req_r <= 1'b0;  we_r <= 1'b0;  wide_r <= 1'b0;  addr_r <= 16'h0000;  wdata_r <= 16'h0000;
      fidx_r <= 16'h0000;  left_r <= 16'h0000;  ncr_r <= 4'h0;  txd_r <= 1'b0;  txen_r <= 1'b0;
      bitc_r <= 6'h00;  prec_r <= 3'h0;  crc_r <= CRC_INIT;  go_r <= 1'b0;  done_r <= 1'b0;
      bdiv_r <= 5'h00;  ifg_r <= 11'h000;
    end else begin
      st_r <= st_nxt;  bnd_r <= bnd_nxt;  hnext_r <= hnext_nxt;  hstat_r <= hstat_nxt;
      hpage_r <= hpage_nxt;  hcnt_r <= hcnt_nxt;  hpend_r <= hpend_nxt;  rcnt_r <= rcnt_nxt;
      rnext_r <= rnext_nxt;  tsr_r <= tsr_nxt;  nb_r <= nb_nxt;  nbv_r <= nbv_nxt;  sh_r <= sh_nxt;
      step_r <= step_nxt;  req_r <= req_nxt;  we_r <= we_nxt;  wide_r <= wide_nxt;
      addr_r <= addr_nxt;  wdata_r <= wdata_nxt;  fidx_r <= fidx_nxt;  left_r <= left_nxt;
      ncr_r <= ncr_nxt;  txd_r <= txd_nxt;  txen_r <= txen_nxt;  bitc_r <= bitc_nxt;
      prec_r <= prec_nxt;  crc_r <= crc_nxt;  go_r <= go_nxt;  done_r <= done_nxt;
      bdiv_r <= bdiv_nxt;  ifg_r <= ifg_nxt;
    end
  end

  assign O_RX_PAGE_DENY = I_RX_PAGE_REQ && (I_RX_PAGE == bnd_r);
  assign O_RX_WR_READY  = (st_r == RBATD_IDLE) && !hpend_r && !req_r && !I_TX_REQUEST && !I_SEND_PKT;
  assign O_RING_READ_LIMIT_PAGE   = bnd_r;
  assign O_REMOTE_GO              = go_r;
  assign O_REMOTE_START_ADDR_LOW  = 8'h00;
  assign O_REMOTE_START_ADDR_HIGH = bnd_r;
  assign O_REMOTE_COUNT           = rcnt_r;
  assign O_TXD                    = txd_r;
  assign O_TX_EN                  = txen_r;
  assign O_TX_STATUS_REG          = tsr_r;
  assign O_COLLISION_COUNT_REG    = ncr_r;
  assign O_TX_DONE                = done_r;
  assign O_BUSY                   = (st_r != RBATD_IDLE);
  assign O_MEM_REQ                = req_r;
  assign O_MEM_WE                 = we_r;
  assign O_MEM_WIDE               = wide_r;
  assign O_MEM_ADDR               = addr_r;
  assign O_MEM_WDATA              = wdata_r;
endmodule : rbatd_top

// ===== tb_rbatd_top.sv
// self-checking testbench for the ring buffer and transmit dma
`timescale 1ns/100ps
module tb_rbatd_top;
  import rbatd_pkg::*;
  logic        I_MCLK = 1'b0, I_RESETN = 1'b0, I_BYTE_SWAP_SELECT = 1'b0, I_WORD_WIDTH_SELECT = 1'b0;
  logic        I_RING_READ_LIMIT_WR = 1'b0, I_SEND_PKT = 1'b0, I_REMOTE_DONE = 1'b0, I_RX_PAGE_REQ = 1'b0;
  logic        I_RX_ACCEPT = 1'b0, I_RX_WR = 1'b0, I_TX_REQUEST = 1'b0, I_RECEIVING = 1'b0, I_CRS = 1'b0;
  logic        I_COL = 1'b0, I_MEM_ACK, slow = 1'b0;
  logic [7:0]  I_RING_FIRST_PAGE = 8'h40, I_RING_END_PAGE = 8'h60, I_RING_READ_LIMIT_DATA = 8'h00;
  logic [7:0]  I_RX_PAGE = 8'h00, I_RING_WRITE_PAGE = 8'h00, I_RX_NEXT_PAGE = 8'h00, I_RX_STATUS = 8'h00;
  logic [7:0]  I_TX_PAGE_START = 8'h20, I_TX_COUNT_LOW = 8'h40, I_TX_COUNT_HIGH = 8'h00;
  logic [15:0] I_RX_COUNT = 16'h0000, I_RX_ADDR = 16'h0000, I_RX_WORD = 16'h0000, I_MEM_RDATA;
  logic [7:0]  O_RING_READ_LIMIT_PAGE, O_REMOTE_START_ADDR_LOW, O_REMOTE_START_ADDR_HIGH, O_TX_STATUS_REG;
  logic [15:0] O_REMOTE_COUNT, O_MEM_ADDR, O_MEM_WDATA;
  logic [3:0]  O_COLLISION_COUNT_REG;
  logic        O_REMOTE_GO, O_RX_PAGE_DENY, O_RX_WR_READY, O_TXD, O_TX_EN, O_TX_DONE, O_BUSY;
  logic        O_MEM_REQ, O_MEM_WE, O_MEM_WIDE;
  int          err_count = 0, checks = 0, cyc = 0, en_cyc = 0;
  // short slot keeps fifteen backoffs inside the run budget
  rbatd_top #(.SLOT_CYC(2)) u_dut (.*);
  rbatd_mem_model u_mem (.i_clk(I_MCLK), .i_req(O_MEM_REQ), .i_we(O_MEM_WE), .i_wide(O_MEM_WIDE),
    .i_addr(O_MEM_ADDR), .i_wdata(O_MEM_WDATA), .i_slow(slow), .o_ack(I_MEM_ACK), .o_rdata(I_MEM_RDATA));
  always #2 I_MCLK = ~I_MCLK;
  always @(posedge I_MCLK) begin
    cyc++;
    if (O_TX_EN === 1'b1) en_cyc++;
    if (cyc == 100000) begin
      err_count++;
      close_out();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge I_MCLK);
    #1;
  endtask : step
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wait_on(ref logic sig, input logic lvl, input int lim);
    while (sig !== lvl && lim > 0) begin
      step(1);
      lim--;
    end
  endtask : wait_on
  task automatic close_out();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out
  task automatic t_hdr();
    logic [15:0] b;
    for (int m = 0; m < 3; m++) begin
      slow = m[0];
      I_WORD_WIDTH_SELECT = m > 0;
      I_BYTE_SWAP_SELECT = m == 2;
      I_RING_WRITE_PAGE = 8'h41 + 8'(m);
      I_RX_STATUS = 8'h21;
      I_RX_NEXT_PAGE = 8'h47;
      I_RX_COUNT = 16'h0a5c;
      I_RX_ACCEPT = 1'b1;
      step(1);
      I_RX_ACCEPT = 1'b0;
      step(2);
      wait_on(O_BUSY, 1'b0, 200);
      b = {I_RING_WRITE_PAGE, 8'h00};
      chk("hdr status", 16'h0021, {8'h00, u_mem.mem[b]});
      chk("hdr next", 16'h0047, {8'h00, u_mem.mem[b + 1]});
      chk("hdr count", m == 2 ? 16'h5c0a : 16'h0a5c, {u_mem.mem[b + 3], u_mem.mem[b + 2]});
      if (m > 0) begin
        I_RX_ADDR = b + 16'h0004;
        I_RX_WORD = 16'h2211;
        I_RX_WR = 1'b1;
        wait_on(O_RX_WR_READY, 1'b1, 50);
        chk("wr ready", 16'h0001, {15'h0000, O_RX_WR_READY});
        step(1);
        I_RX_WR = 1'b0;
        step(20);
        chk("rx data", m == 2 ? 16'h1122 : 16'h2211, {u_mem.mem[b + 5], u_mem.mem[b + 4]});
      end
    end
  endtask : t_hdr
  task automatic t_send(input logic [7:0] nxt, input logic [7:0] lim);
    I_BYTE_SWAP_SELECT = 1'b0;
    I_RING_READ_LIMIT_DATA = 8'h45;
    I_RING_READ_LIMIT_WR = 1'b1;
    step(1);
    I_RING_READ_LIMIT_WR = 1'b0;
    I_RX_PAGE_REQ = 1'b1;
    I_RX_PAGE = 8'h45;
    step(1);
    chk("limit write", 16'h0045, {8'h00, O_RING_READ_LIMIT_PAGE});
    chk("deny hit", 16'h0001, {15'h0000, O_RX_PAGE_DENY});
    I_RX_PAGE = 8'h46;
    #1;
    chk("deny miss", 16'h0000, {15'h0000, O_RX_PAGE_DENY});
    I_RX_PAGE_REQ = 1'b0;
    u_mem.mem[16'h4501] = nxt;
    u_mem.mem[16'h4502] = 8'h3c;
    u_mem.mem[16'h4503] = 8'h01;
    I_SEND_PKT = 1'b1;
    step(1);
    I_SEND_PKT = 1'b0;
    wait_on(O_REMOTE_GO, 1'b1, 200);
    chk("remote go", 16'h0001, {15'h0000, O_REMOTE_GO});
    chk("remote count", 16'h013c, O_REMOTE_COUNT);
    chk("remote addr", 16'h4500, {O_REMOTE_START_ADDR_HIGH, O_REMOTE_START_ADDR_LOW});
    step(3);
    I_REMOTE_DONE = 1'b1;
    step(1);
    I_REMOTE_DONE = 1'b0;
    step(2);
    chk("limit advance", {8'h00, lim}, {8'h00, O_RING_READ_LIMIT_PAGE});
  endtask : t_send
  task automatic start_tx(input logic wide, input logic sw);
    I_WORD_WIDTH_SELECT = wide;
    I_BYTE_SWAP_SELECT = sw;
    for (int i = 0; i < 64; i++) u_mem.mem[16'h2000 + (i ^ int'(sw))] = 8'h10 + 8'(i);
    I_TX_REQUEST = 1'b1;
    step(1);
    I_TX_REQUEST = 1'b0;
    en_cyc = 0;
  endtask : start_tx
  task automatic t_tx(input logic wide, input logic sw);
    logic [7:0] exp;
    start_tx(wide, sw);
    wait_on(O_TX_EN, 1'b1, 4000);
    step(12);
    for (int k = 0; k < 96; k++) begin
      exp = k < 56 ? PRE_BYTE : k < 64 ? SFD_BYTE : 8'h10 + 8'((k - 64) / 8);
      chk("txd bit", {15'h0000, exp[k % 8]}, {15'h0000, O_TXD});
      step(25);
    end
    wait_on(O_TX_DONE, 1'b1, 20000);
    chk("tx done", 16'h0001, {15'h0000, O_TX_DONE});
    chk("tx sent", 16'h0001, {15'h0000, O_TX_STATUS_REG[TSR_PTX_BIT]});
    chk("tx length", 16'h3b60, 16'(en_cyc));
  endtask : t_tx
  task automatic t_col();
    start_tx(1'b1, 1'b0);
    for (int a = 1; a <= 16; a++) begin
      wait_on(O_TX_EN, 1'b1, 6000);
      step(40);
      I_COL = 1'b1;
      step(1);
      I_COL = 1'b0;
      step(2);
      chk("col count", a < 16 ? 16'(a) : 16'h0000, {12'h000, O_COLLISION_COUNT_REG});
    end
    chk("col flag", 16'h0001, {15'h0000, O_TX_STATUS_REG[TSR_COL_BIT]});
    chk("abort flag", 16'h0001, {15'h0000, O_TX_STATUS_REG[TSR_ABT_BIT]});
  endtask : t_col
  task automatic t_crs();
    I_RECEIVING = 1'b1;
    start_tx(1'b1, 1'b0);
    step(4);
    I_CRS = 1'b1;
    step(3);
    chk("crs abandon", 16'h0000, {14'h0000, O_BUSY, O_TX_EN});
    I_CRS = 1'b0;
    I_RECEIVING = 1'b0;
  endtask : t_crs
  initial begin
    step(5);
    I_RESETN = 1'b1;
    step(1);
    t_hdr();
    t_send(8'h4a, 8'h49);
    t_send(8'h40, 8'h5f);
    t_crs();
    t_tx(1'b1, 1'b1);
    t_tx(1'b0, 1'b0);
    t_col();
    close_out();
  end
endmodule : tb_rbatd_top
